// ### pmp_defines.svh
// Constants of the management port: frame fields, register offsets, reset values, counts
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH

`define PMP_PRE_LEN 6'h20
`define PMP_OP_RD 2'h2
`define PMP_OP_WR 2'h1
`define PMP_DATA_BITS 6'h10
`define PMP_LAST_ADR_BIT 6'h09
`define PMP_LAST_DAT_BIT 6'h0F
`define PMP_TA_LAST 6'h01
`define PMP_OP_LAST 6'h01

`define PMP_REG_STRAP 5'h10
`define PMP_REG_IMASK 5'h12
`define PMP_REG_ISTAT 5'h13
`define PMP_REG_LEDCTL 5'h14

`define PMP_IMASK_RST 16'h0001
`define PMP_LEDCTL_RST 16'h3210
`define PMP_READY_BIT 0

`define PMP_STRAP_CYC 3'h6

`endif

// ### pmp_pkg.sv
// Types of the management port
package pmp_pkg;
	typedef enum logic [2:0] {ST_PRE, ST_START, ST_OP, ST_ADR, ST_RTA, ST_RDAT, ST_WTA, ST_WDAT}
		pmp_state_t;
endpackage

// ### pmp_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d_in,
	output var logic [W-1:0] q_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a change only once the second and third stages agree
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				q_out[i] <= 1'b0;
			end else if (s2_q[i] == s3_q[i]) begin
				q_out[i] <= s3_q[i];
			end
		end
	end
endmodule
`default_nettype wire

// ### pmp_mgmt.sv
// Management port top: serial slave, interrupt pin and indicator pins
`timescale 1ns/1ps
`default_nettype none
`include "pmp_defines.svh"

// Functional notes
// - Line drive changes only at clock rise
// - Incoming data sampled at clock rise
// - Pull-up on only while pin is input
// - Mask selects which events raise interrupt
// - Interrupt pin floats unless asserting
// - Active level follows external resistor
// - Drive only active level, wired-or safe
// - Assert interrupt when ready after reset
// - Status read deasserts interrupt
// - Indicator pins latched as straps
// - Indicator pins become selectable outputs
module pmp_mgmt (
	input wire logic clk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_i,
	output var logic mdio_o,
	output var logic mdio_oe,
	output var logic mdio_pu_en,
	input wire logic [4:0] phy_addr,
	input wire logic [14:0] event_in,
	input wire logic [7:0] status_in,
	input wire logic mgmt_irq_out_i,
	output var logic mgmt_irq_out_o,
	output var logic mgmt_irq_out_oe,
	input wire logic indicator_pin_0_i,
	output var logic indicator_pin_0_o,
	output var logic indicator_pin_0_oe,
	input wire logic indicator_pin_1_i,
	output var logic indicator_pin_1_o,
	output var logic indicator_pin_1_oe,
	input wire logic indicator_pin_2_i,
	output var logic indicator_pin_2_o,
	output var logic indicator_pin_2_oe,
	input wire logic indicator_pin_3_i,
	output var logic indicator_pin_3_o,
	output var logic indicator_pin_3_oe,
	output var logic [3:0] strap_cfg
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic mdc_s;
	logic mdio_s;
	logic irq_s;
	logic [3:0] led_s;

	pmp_sync #(.W(7)) u_sync (
		.clk(clk),
		.reset(reset),
		.d_in({mdc, mdio_i, mgmt_irq_out_i, indicator_pin_3_i, indicator_pin_2_i,
			indicator_pin_1_i, indicator_pin_0_i}),
		.q_out({mdc_s, mdio_s, irq_s, led_s})
	);

	// ----------------------------------------
	// Serial frame engine
	// ----------------------------------------
	pmp_pkg::pmp_state_t st_q, st_d;
	logic [5:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic [15:0] rdat_q, rdat_d;
	logic [4:0] reg_q, reg_d;
	logic op_rd_q, op_rd_d;
	logic mdc_prev_q, mdc_prev_d;
	logic mdio_prev_q, mdio_prev_d;
	logic mdo_q, mdo_d;
	logic mdoe_q, mdoe_d;
	logic pu_q, pu_d;
	logic rise;
	logic bit_in;
	logic wr_stb;
	logic rd_clr;

	logic [15:0] imask_q, imask_d;
	logic [15:0] istat_q, istat_d;
	logic [15:0] ledctl_q, ledctl_d;
	logic [3:0] strap_q, strap_d;
	logic done_q, done_d;
	logic pol_low_q, pol_low_d;
	logic [2:0] wcnt_q, wcnt_d;
	logic [14:0] ev_prev_q;
	logic [15:0] set;
	logic active;

	function automatic logic [15:0] rd_mux(input logic [4:0] a);
		unique case (a)
			`PMP_REG_STRAP: rd_mux = {12'h000, strap_q};
			`PMP_REG_IMASK: rd_mux = imask_q;
			`PMP_REG_ISTAT: rd_mux = istat_q;
			`PMP_REG_LEDCTL: rd_mux = ledctl_q;
			default: rd_mux = 16'h0000;
		endcase
	endfunction

	// Line value one cycle before the detected edge is the settled bit
	assign rise = mdc_s & ~mdc_prev_q;
	assign bit_in = mdio_prev_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rdat_d = rdat_q;
		reg_d = reg_q;
		op_rd_d = op_rd_q;
		mdc_prev_d = mdc_s;
		mdio_prev_d = mdio_s;
		mdo_d = mdo_q;
		mdoe_d = mdoe_q;
		wr_stb = 1'b0;
		rd_clr = 1'b0;
		if (rise) begin
			unique case (st_q)
				pmp_pkg::ST_PRE: begin
					if (bit_in) begin
						if (cnt_q != `PMP_PRE_LEN) begin
							cnt_d = cnt_q + 6'h01;
						end
					end else if (cnt_q == `PMP_PRE_LEN) begin
						st_d = pmp_pkg::ST_START;
					end else begin
						cnt_d = 6'h00;
					end
				end
				pmp_pkg::ST_START: begin
					cnt_d = 6'h00;
					st_d = bit_in ? pmp_pkg::ST_OP : pmp_pkg::ST_PRE;
				end
				pmp_pkg::ST_OP: begin
					sh_d = {sh_q[14:0], bit_in};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == `PMP_OP_LAST) begin
						cnt_d = 6'h00;
						op_rd_d = (sh_d[1:0] == `PMP_OP_RD);
						if (sh_d[1:0] == `PMP_OP_RD || sh_d[1:0] == `PMP_OP_WR) begin
							st_d = pmp_pkg::ST_ADR;
						end else begin
							st_d = pmp_pkg::ST_PRE;
						end
					end
				end
				pmp_pkg::ST_ADR: begin
					sh_d = {sh_q[14:0], bit_in};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == `PMP_LAST_ADR_BIT) begin
						cnt_d = 6'h00;
						reg_d = sh_d[4:0];
						if (sh_d[9:5] != phy_addr) begin
							st_d = pmp_pkg::ST_PRE;
						end else if (op_rd_q) begin
							st_d = pmp_pkg::ST_RTA;
							rdat_d = rd_mux(sh_d[4:0]);
							rd_clr = (sh_d[4:0] == `PMP_REG_ISTAT);
						end else begin
							st_d = pmp_pkg::ST_WTA;
						end
					end
				end
				// take the line only at a rise
				pmp_pkg::ST_RTA: begin
					mdoe_d = 1'b1;
					mdo_d = 1'b0;
					st_d = pmp_pkg::ST_RDAT;
				end
				pmp_pkg::ST_RDAT: begin
					if (cnt_q == `PMP_DATA_BITS) begin
						mdoe_d = 1'b0;
						cnt_d = 6'h00;
						st_d = pmp_pkg::ST_PRE;
					end else begin
						mdo_d = rdat_q[15];
						rdat_d = {rdat_q[14:0], 1'b0};
						cnt_d = cnt_q + 6'h01;
					end
				end
				pmp_pkg::ST_WTA: begin
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == `PMP_TA_LAST) begin
						cnt_d = 6'h00;
						st_d = pmp_pkg::ST_WDAT;
					end
				end
				pmp_pkg::ST_WDAT: begin
					sh_d = {sh_q[14:0], bit_in};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == `PMP_LAST_DAT_BIT) begin
						wr_stb = 1'b1;
						cnt_d = 6'h00;
						st_d = pmp_pkg::ST_PRE;
					end
				end
			endcase
		end
		pu_d = ~mdoe_d;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= pmp_pkg::ST_PRE;
			cnt_q <= 6'h00;
			sh_q <= 16'h0000;
			rdat_q <= 16'h0000;
			reg_q <= 5'h00;
			op_rd_q <= 1'b0;
			mdc_prev_q <= 1'b0;
			mdio_prev_q <= 1'b0;
			mdo_q <= 1'b0;
			mdoe_q <= 1'b0;
			pu_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rdat_q <= rdat_d;
			reg_q <= reg_d;
			op_rd_q <= op_rd_d;
			mdc_prev_q <= mdc_prev_d;
			mdio_prev_q <= mdio_prev_d;
			mdo_q <= mdo_d;
			mdoe_q <= mdoe_d;
			pu_q <= pu_d;
		end
	end

	// ----------------------------------------
	// Registers, straps, interrupt, indicators
	// ----------------------------------------
	logic [3:0] led_val;
	logic [3:0] led_o_q;
	logic led_oe_q;
	logic irq_o_q, irq_oe_q;

	for (genvar i = 0; i < 4; i++) begin : g_led
		assign led_val[i] = status_in[ledctl_q[4*i +: 3]] ^ ledctl_q[4*i+3];
	end

	assign active = done_q & (|(istat_q & imask_q));

	always_comb begin
		imask_d = imask_q;
		ledctl_d = ledctl_q;
		strap_d = strap_q;
		done_d = done_q;
		pol_low_d = pol_low_q;
		wcnt_d = wcnt_q;
		set = {event_in & ~ev_prev_q, 1'b0};
		// latch straps once the synchronisers settle
		if (!done_q) begin
			wcnt_d = wcnt_q + 3'h1;
			if (wcnt_q == `PMP_STRAP_CYC) begin
				strap_d = led_s;
				pol_low_d = irq_s;
				done_d = 1'b1;
				set[`PMP_READY_BIT] = 1'b1;
			end
		end
		if (wr_stb && reg_q == `PMP_REG_IMASK) begin
			imask_d = sh_d;
		end
		if (wr_stb && reg_q == `PMP_REG_LEDCTL) begin
			ledctl_d = sh_d;
		end
		// read clears, a new event still wins
		istat_d = (rd_clr ? 16'h0000 : istat_q) | set;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			imask_q <= `PMP_IMASK_RST;
			istat_q <= 16'h0000;
			ledctl_q <= `PMP_LEDCTL_RST;
			strap_q <= 4'h0;
			done_q <= 1'b0;
			pol_low_q <= 1'b1;
			wcnt_q <= 3'h0;
			ev_prev_q <= 15'h0000;
			irq_o_q <= 1'b0;
			irq_oe_q <= 1'b0;
			led_o_q <= 4'h0;
			led_oe_q <= 1'b0;
		end else begin
			imask_q <= imask_d;
			istat_q <= istat_d;
			ledctl_q <= ledctl_d;
			strap_q <= strap_d;
			done_q <= done_d;
			pol_low_q <= pol_low_d;
			wcnt_q <= wcnt_d;
			ev_prev_q <= event_in;
			irq_oe_q <= active;
			irq_o_q <= ~pol_low_q;
			led_o_q <= led_val;
			led_oe_q <= done_q;
		end
	end

	assign mdio_o = mdo_q;
	assign mdio_oe = mdoe_q;
	assign mdio_pu_en = pu_q;
	assign mgmt_irq_out_o = irq_o_q;
	assign mgmt_irq_out_oe = irq_oe_q;
	assign {indicator_pin_3_o, indicator_pin_2_o, indicator_pin_1_o, indicator_pin_0_o} = led_o_q;
	assign indicator_pin_0_oe = led_oe_q;
	assign indicator_pin_1_oe = led_oe_q;
	assign indicator_pin_2_oe = led_oe_q;
	assign indicator_pin_3_oe = led_oe_q;
	assign strap_cfg = strap_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_drive_on_rise: assert property ($changed(mdo_q) || $changed(mdoe_q) |-> $past(rise))
		else $error("line drive changed without clock rise");
	a_sample_on_rise: assert property ($changed(st_q) |-> $past(rise))
		else $error("frame state moved without clock rise");
	a_pullup_release: assert property (##1 (pu_q != mdoe_q))
		else $error("pull-up on while driving");
	a_mask_gates: assert property ($past(active) |-> irq_oe_q)
		else $error("masked event did not assert interrupt");
	a_irq_float: assert property (!$past(active) |-> !irq_oe_q)
		else $error("interrupt driven while none pending");
	a_irq_level: assert property (irq_oe_q && $past(done_q, 2) |-> irq_o_q == !pol_low_q)
		else $error("interrupt driven at wrong level");
	a_ready_irq: assert property ($rose(done_q) |-> istat_q[0] ##2 irq_oe_q)
		else $error("no ready interrupt after reset");
	a_read_clears: assert property (rd_clr && set == 16'h0000 |=> istat_q == 16'h0000)
		else $error("status read did not clear");
	a_strap_hold: assert property (done_q && $past(done_q) |-> $stable(strap_q))
		else $error("strap value changed after capture");
	a_led_enable: assert property (##1 (led_oe_q == $past(done_q)))
		else $error("indicator enable wrong");
	a_read_order: assert property (st_q == pmp_pkg::ST_RTA |-> $past(st_q) inside
		{pmp_pkg::ST_ADR, pmp_pkg::ST_RTA})
		else $error("turnaround without address phase");
endmodule
`default_nettype wire

// ### pmp_sta.sv
// Station management controller model for the serial management link
`timescale 1ns/1ps
`default_nettype none
module pmp_sta (
	output var logic mdc,
	output var logic host_d,
	output var logic host_oe,
	input wire logic line
);
	// ----------------
	// Bit clocking
	// ----------------
	initial begin
		mdc = 1'b0;
		host_d = 1'b1;
		host_oe = 1'b0;
	end
	task automatic bit_cyc(input logic oe, input logic d, output logic s);
		s = line;
		mdc = 1'b1;
		#1;
		host_oe = oe;
		host_d = d;
		#399;
		mdc = 1'b0;
		#400;
	endtask
	task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [45:0] hdr;
		logic s;
		hdr = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra};
		rdat = 16'h0000;
		for (int i = 45; i >= 0; i--) begin
			bit_cyc(1'b1, hdr[i], s);
		end
		if (rd) begin
			bit_cyc(1'b0, 1'b1, s);
			for (int j = 0; j < 18; j++) begin
				bit_cyc(1'b0, 1'b1, s);
				if (j >= 2) begin
					rdat = {rdat[14:0], s};
				end
			end
		end else begin
			bit_cyc(1'b1, 1'b1, s);
			bit_cyc(1'b1, 1'b0, s);
			for (int j = 15; j >= 0; j--) begin
				bit_cyc(1'b1, wd[j], s);
			end
			// Line released once the last bit is taken
			bit_cyc(1'b0, 1'b1, s);
		end
	endtask
endmodule
`default_nettype wire

// ### test_phy_mgmt_port_irq_leds.sv
// Self-checking bench of the management port
`timescale 1ns/1ps
`default_nettype none
module test_phy_mgmt_port_irq_leds;
	localparam logic [4:0] ADR = 5'h05;
	logic clk, reset, mdc, host_d, host_oe, mdio_line, mdio_o, mdio_oe, mdio_pu_en;
	logic irq_pull, irq_pad, irq_o, irq_oe, oe_seen;
	logic [14:0] event_in;
	logic [7:0] status_in;
	logic [3:0] strap, led_pad, strap_cfg;
	// Per-pin ports drive single bits, so these must be nets
	wire logic [3:0] led_o;
	wire logic [3:0] led_oe;
	logic [15:0] rd;
	int miscompares = 0;
	int compares = 0;
	// ----------------
	// Pads and instances
	// ----------------
	// Undriven line without pull-up shows a changing level, not a stale one
	assign mdio_line = host_oe ? host_d : mdio_oe ? mdio_o : mdio_pu_en ? 1'b1 : ~mdio_o;
	assign irq_pad = irq_oe ? irq_o : irq_pull;
	assign led_pad = (led_oe & led_o) | (~led_oe & strap);
	pmp_sta u_sta (.mdc(mdc), .host_d(host_d), .host_oe(host_oe), .line(mdio_line));
	pmp_mgmt DUT (.clk(clk), .reset(reset), .mdc(mdc), .mdio_i(mdio_line),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_pu_en(mdio_pu_en), .phy_addr(ADR),
		.event_in(event_in), .status_in(status_in), .mgmt_irq_out_i(irq_pad),
		.mgmt_irq_out_o(irq_o), .mgmt_irq_out_oe(irq_oe),
		.indicator_pin_0_i(led_pad[0]), .indicator_pin_0_o(led_o[0]),
		.indicator_pin_0_oe(led_oe[0]), .indicator_pin_1_i(led_pad[1]),
		.indicator_pin_1_o(led_o[1]), .indicator_pin_1_oe(led_oe[1]),
		.indicator_pin_2_i(led_pad[2]), .indicator_pin_2_o(led_o[2]),
		.indicator_pin_2_oe(led_oe[2]), .indicator_pin_3_i(led_pad[3]),
		.indicator_pin_3_o(led_o[3]), .indicator_pin_3_oe(led_oe[3]),
		.strap_cfg(strap_cfg));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------
	// Helpers
	// ----------------
	task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (10) @(negedge clk);
	endtask
	task automatic pulse(input logic [14:0] ev);
		@(negedge clk);
		event_in = ev;
		@(negedge clk);
		event_in = 15'h0000;
		repeat (5) @(negedge clk);
	endtask
	always @(posedge clk) begin
		if (mdio_oe === 1'b1) begin
			oe_seen = 1'b1;
		end
	end
	// Pull-up must be off exactly while the device drives
	always @(negedge clk) begin
		if (!reset) begin
			cmp_b(mdio_pu_en, ~mdio_oe);
		end
	end
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_ready();
		for (int p = 0; p < 2; p++) begin
			@(negedge clk);
			reset = 1'b1;
			irq_pull = p[0];
			strap = p[0] ? 4'hA : 4'h5;
			repeat (8) @(negedge clk);
			reset = 1'b0;
			repeat (20) @(negedge clk);
			cmp_b(irq_oe, 1'b1);
			cmp_b(irq_o, ~p[0]);
			cmp_b(irq_pad, ~p[0]);
			cmp_w({12'h000, strap_cfg}, {12'h000, strap});
			cmp_w({12'h000, led_oe}, 16'h000F);
			u_sta.frame(1'b1, ADR, 5'h10, 16'h0000, rd);
			cmp_w(rd, {12'h000, strap});
		end
		$display("t_ready done");
	endtask
	task automatic t_istat();
		cmp_b(irq_oe, 1'b1);
		u_sta.frame(1'b1, ADR, 5'h13, 16'h0000, rd);
		cmp_w(rd, 16'h0001);
		settle();
		cmp_b(irq_oe, 1'b0);
		cmp_b(irq_pad, irq_pull);
		$display("t_istat done");
	endtask
	task automatic t_mask();
		u_sta.frame(1'b0, ADR, 5'h12, 16'h0004, rd);
		settle();
		u_sta.frame(1'b1, ADR, 5'h12, 16'h0000, rd);
		cmp_w(rd, 16'h0004);
		pulse(15'h0001);
		cmp_b(irq_oe, 1'b0);
		pulse(15'h0002);
		cmp_b(irq_oe, 1'b1);
		u_sta.frame(1'b1, ADR, 5'h13, 16'h0000, rd);
		cmp_w(rd, 16'h0006);
		settle();
		cmp_b(irq_oe, 1'b0);
		$display("t_mask done");
	endtask
	task automatic t_led();
		status_in = 8'h06;
		u_sta.frame(1'b0, ADR, 5'h14, 16'h8A51, rd);
		settle();
		cmp_w({12'h000, led_o}, 16'h0009);
		cmp_w({12'h000, led_pad}, 16'h0009);
		$display("t_led done");
	endtask
	task automatic t_refuse();
		oe_seen = 1'b0;
		u_sta.frame(1'b1, ADR ^ 5'h01, 5'h12, 16'h0000, rd);
		cmp_b(oe_seen, 1'b0);
		cmp_w(rd, 16'hFFFF);
		u_sta.frame(1'b1, ADR, 5'h12, 16'h0000, rd);
		cmp_w(rd, 16'h0004);
		$display("t_refuse done");
	endtask
	// ----------------
	// Main sequence and watchdog
	// ----------------
	initial begin
		reset = 1'b1;
		irq_pull = 1'b1;
		strap = 4'h5;
		event_in = 15'h0000;
		status_in = 8'h00;
		oe_seen = 1'b0;
		t_ready();
		t_istat();
		t_mask();
		t_led();
		t_refuse();
		close_out();
	end
	// About nine frames of 52 us each; generous margin
	initial begin
		#3000000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
